// ### pkg/cmt_pkg.sv
// constants and carrier types for the two-channel compare-match timer/counter
// assumes one 50 MHz system clock and an AXI4-Lite register port with 32-bit data
package cmt_pkg;
  localparam int NCH = 2;
  localparam int CNT_W = 8;
  localparam int PRE_W = 12;
  localparam int AXI_AW = 16;
  localparam int AXI_DW = 32;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_MODE0 = 12'hf90;
  localparam logic [11:0] IDX_MODE1 = 12'hfa0;
  localparam logic [11:0] IDX_OUT_EN = 12'hf92;
  localparam logic [11:0] IDX_CNT0 = 12'hf94;
  localparam logic [11:0] IDX_CNT1 = 12'hfa4;
  localparam logic [11:0] IDX_REF0 = 12'hf96;
  localparam logic [11:0] IDX_REF1 = 12'hfa6;
  localparam logic [11:0] IDX_STAT = 12'hf98;
  // mode register fields
  localparam int MODE_SEL_LSB = 4;
  localparam int MODE_RESTART_BIT = 3;
  localparam int MODE_EN_BIT = 2;
  // output enable register fields
  localparam int OE_CH0_BIT = 2;
  localparam int OE_CH1_BIT = 3;
  localparam int OE_BASIC_BIT = 1;
  // status register fields
  localparam int STAT_IRQ_LSB = 0;
  localparam int STAT_LATCH_LSB = 2;
  // values after reset
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'hff;
  localparam logic [PRE_W-1:0] PRE_RST = 12'h000;
  // clock source select codes
  localparam logic [2:0] SEL_EXT_RISE = 3'h0;
  localparam logic [2:0] SEL_EXT_FALL = 3'h1;
  // divider exponents for codes 1xx, code 111 in the top nibble
  localparam logic [15:0] EXP_CH0 = {4'h0, 4'h4, 4'h6, 4'ha};
  localparam logic [15:0] EXP_CH1 = {4'h6, 4'h8, 4'ha, 4'hc};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic en;
    logic [2:0] sel;
  } cmt_mode_t;

  localparam cmt_mode_t MODE_RST = '{en: 1'b0, sel: 3'h0};

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b00,
    WR_RESP = 2'b01
  } cmt_wr_state_t;
endpackage

// ### rtl/cmt_channel.sv
// one timer/counter channel: counter, compare reference, output latch, interrupt flag
// assumes an active-low reset that the top releases synchronously, and a one-cycle counting event
`timescale 1ns/100ps
module cmt_channel #(
  parameter int CW = cmt_pkg::CNT_W
) (
  input logic clk_i,
  input logic rst_b_i,
  input cmt_pkg::cmt_mode_t mode_i,
  input logic restart_i,
  input logic tick_i,
  input logic ref_wr_i,
  input logic [CW-1:0] ref_data_i,
  input logic irq_clr_i,
  output logic [CW-1:0] cnt_o,
  output logic latch_o,
  output logic irq_o
);
  import cmt_pkg::*;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] ref_r;
  logic latch_r;
  logic irq_r;
  logic match;

  // the counter sits at the reference for one full period, so the interval is reference plus one
  assign match = mode_i.en && tick_i && (cnt_r == ref_r);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_r <= CW'(CNT_RST);
    else if (restart_i)
      cnt_r <= '0;
    else if (match)
      cnt_r <= '0;
    else if (mode_i.en && tick_i)
      cnt_r <= CW'(cnt_r + 1'b1);
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ref_r <= CW'(REF_RST);
    else if (ref_wr_i)
      ref_r <= ref_data_i;
  end

  // latch keeps its state over restart and while disabled
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      latch_r <= 1'b0;
    else if (match && !restart_i)
      latch_r <= ~latch_r;
  end

  // a match in the cycle of a software clear wins
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      irq_r <= 1'b0;
    else if (restart_i)
      irq_r <= 1'b0;
    else if (match)
      irq_r <= 1'b1;
    else if (irq_clr_i)
      irq_r <= 1'b0;
  end

  assign cnt_o = cnt_r;
  assign latch_o = latch_r;
  assign irq_o = irq_r;

  chk_restart_clears: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    restart_i |=> (cnt_r == '0) && !irq_r && $stable(latch_r))
    else $error("restart did not clear counter and flag or moved the latch");
  chk_count_step: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !restart_i && mode_i.en && tick_i && (cnt_r != ref_r) |=> cnt_r == CW'($past(cnt_r) + 1'b1))
    else $error("counter did not step by one on an event");
  chk_match_wrap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !restart_i && match |=> (cnt_r == '0) && irq_r && (latch_r != $past(latch_r)))
    else $error("match did not wrap, flag and toggle");
  chk_hold_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !restart_i && !mode_i.en |=> $stable(cnt_r) && $stable(latch_r))
    else $error("disabled channel changed its counter or latch");
  chk_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    irq_r && !irq_clr_i && !restart_i |=> irq_r)
    else $error("interrupt flag dropped without a clear");
  cov_match: cover property (@(posedge clk_i) disable iff (!rst_b_i) match ##1 irq_clr_i);
endmodule // cmt_channel

// ### rtl/cmt_top.sv
// two-channel compare-match timer/counter with an AXI4-Lite register port
// assumes mclk_i at 50 MHz, event pins synchronous-safe via local synchronisers,
// and a master that keeps at most one write and one read under way
//
// Summary of operation
// - counter value is 8 bits, readable, writes to it are ignored.
// - reset forces every counter value to zero.
// - setting the restart bit clears the counter and counting resumes.
// - counter steps by one on each event chosen by the source select.
// - counter equal to reference sets the sticky interrupt flag and request.
// - compare reference is 8 bits, writable, reads back as zero.
// - reset loads every compare reference with all ones.
// - each match inverts the output latch.
// - nonzero reference gives an interval of reference plus one events.
// - output enable flags sit at bit 3 (channel 1) and bit 2 (channel 0).
// - with its enable set, the latch state drives the clock output pin.
// - reset clears every output enable, so no pin is driven high.
// - restart clears counter and flag, keeps the latch, resumes at once.
// - with the channel disabled the latch holds and stays readable.
// - source codes: external rise/fall, or four fixed system clock divisions.
// - clearing the enable bit stops counting and holds the counter.
// - after a match the counter returns to zero and keeps counting.
// - the restart bit clears itself once counting has restarted.
`timescale 1ns/100ps
module cmt_top (
  input logic mclk_i,
  input logic rst_b_i,
  input logic [cmt_pkg::NCH-1:0] event_clk_i,
  output logic [cmt_pkg::NCH-1:0] timer_clk_o,
  output logic [cmt_pkg::NCH-1:0] timer_irq_o,
  input logic [cmt_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [cmt_pkg::AXI_DW-1:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [cmt_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [cmt_pkg::AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i
);
  import cmt_pkg::*;

  localparam logic [11:0] MODE_IDX [NCH] = '{IDX_MODE0, IDX_MODE1};
  localparam logic [11:0] CNT_IDX [NCH] = '{IDX_CNT0, IDX_CNT1};
  localparam logic [11:0] REF_IDX [NCH] = '{IDX_REF0, IDX_REF1};
  localparam int OE_BIT [NCH] = '{OE_CH0_BIT, OE_CH1_BIT};

  function automatic logic is_idx(input logic [AXI_AW-1:0] a, input logic [11:0] idx);
    return a[AXI_AW-1:2] == {2'b00, idx};
  endfunction

  function automatic logic is_mapped(input logic [AXI_AW-1:0] a);
    return is_idx(a, IDX_MODE0) || is_idx(a, IDX_MODE1) || is_idx(a, IDX_OUT_EN) ||
           is_idx(a, IDX_CNT0) || is_idx(a, IDX_CNT1) || is_idx(a, IDX_REF0) ||
           is_idx(a, IDX_REF1) || is_idx(a, IDX_STAT);
  endfunction

  // exponent of the system clock division for a 1xx source code
  function automatic logic [3:0] div_exp(input int ch, input logic [1:0] sel);
    logic [15:0] tbl;
    tbl = (ch == 0) ? EXP_CH0 : EXP_CH1;
    return tbl[4*sel +: 4];
  endfunction

  // true once every 2^e cycles of the free-running prescaler
  function automatic logic div_tick(input logic [PRE_W-1:0] pre, input logic [3:0] e);
    logic [PRE_W-1:0] m;
    m = '0;
    for (int i = 0; i < PRE_W; i++)
      m[i] = (i < int'(e));
    return (pre & m) == m;
  endfunction

  logic rst_meta_r;
  logic rst_n;
  logic [PRE_W-1:0] pre_r;
  logic [NCH-1:0] ev_meta_r;
  logic [NCH-1:0] ev_sync_r;
  logic [NCH-1:0] ev_prev_r;
  logic [NCH-1:0] tick;
  cmt_mode_t [NCH-1:0] mode_r;
  logic [NCH-1:0] restart_r;
  logic [NCH-1:0] oe_r;
  logic basic_oe_r;
  logic [NCH-1:0] ref_wr;
  logic [NCH-1:0] irq_clr;
  logic [NCH-1:0][CNT_W-1:0] cnt;
  logic [NCH-1:0] latch;
  logic [NCH-1:0] irq;
  logic [NCH-1:0] timer_clk_r;
  logic [NCH-1:0] timer_irq_r;
  cmt_wr_state_t wr_state_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [AXI_DW-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_write;
  logic wr_lane0;
  logic arready_r;
  logic rvalid_r;
  logic [AXI_DW-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic [AXI_DW-1:0] rd_mux;

  // reset released through two flops
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
      pre_r <= PRE_RST;
    else
      pre_r <= PRE_W'(pre_r + 1'b1);
  end

  // only the second stage feeds the edge detector
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_meta_r <= '0;
      ev_sync_r <= '0;
      ev_prev_r <= '0;
    end
    else
    begin
      ev_meta_r <= event_clk_i;
      ev_sync_r <= ev_meta_r;
      ev_prev_r <= ev_sync_r;
    end
  end

  // codes 010 and 011 have no source and never count
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      if (mode_r[c].sel[2])
        tick[c] = div_tick(pre_r, div_exp(c, mode_r[c].sel[1:0]));
      else if (mode_r[c].sel == SEL_EXT_RISE)
        tick[c] = ev_sync_r[c] && !ev_prev_r[c];
      else if (mode_r[c].sel == SEL_EXT_FALL)
        tick[c] = !ev_sync_r[c] && ev_prev_r[c];
      else
        tick[c] = 1'b0;
    end
  end

  // write side: address and data are taken in either order, then applied together
  assign do_write = (wr_state_r == WR_COLLECT) && !awready_r && !wready_r;
  assign wr_lane0 = do_write && wstrb_r[0];

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_state_r <= WR_COLLECT;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      case (wr_state_r)
        WR_COLLECT:
        begin
          if (s_axi_awvalid_i && awready_r)
          begin
            awready_r <= 1'b0;
            awaddr_r <= s_axi_awaddr_i;
          end
          if (s_axi_wvalid_i && wready_r)
          begin
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
          end
          if (do_write)
          begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
            wr_state_r <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (s_axi_bready_i)
          begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wr_state_r <= WR_COLLECT;
          end
        end
        default:
        begin
          wr_state_r <= WR_COLLECT;
          bvalid_r <= 1'b0;
          awready_r <= 1'b1;
          wready_r <= 1'b1;
        end
      endcase
    end
  end

  // mode registers; restart is a one-cycle pulse so it reads back as zero
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= {NCH{MODE_RST}};
      restart_r <= '0;
    end
    else
    begin
      restart_r <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        if (wr_lane0 && is_idx(awaddr_r, MODE_IDX[c]))
        begin
          mode_r[c].en <= wdata_r[MODE_EN_BIT];
          mode_r[c].sel <= wdata_r[MODE_SEL_LSB +: 3];
          restart_r[c] <= wdata_r[MODE_RESTART_BIT];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oe_r <= '0;
      basic_oe_r <= 1'b0;
    end
    else if (wr_lane0 && is_idx(awaddr_r, IDX_OUT_EN))
    begin
      for (int c = 0; c < NCH; c++)
        oe_r[c] <= wdata_r[OE_BIT[c]];
      basic_oe_r <= wdata_r[OE_BASIC_BIT];
    end
  end

  // counter writes are accepted and dropped
  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      ref_wr[c] = wr_lane0 && is_idx(awaddr_r, REF_IDX[c]);
      irq_clr[c] = wr_lane0 && is_idx(awaddr_r, IDX_STAT) && wdata_r[STAT_IRQ_LSB + c];
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
      cmt_channel #(
        .CW(CNT_W)
      ) u_ch (
        .clk_i(mclk_i),
        .rst_b_i(rst_n),
        .mode_i(mode_r[g]),
        .restart_i(restart_r[g]),
        .tick_i(tick[g]),
        .ref_wr_i(ref_wr[g]),
        .ref_data_i(wdata_r[CNT_W-1:0]),
        .irq_clr_i(irq_clr[g]),
        .cnt_o(cnt[g]),
        .latch_o(latch[g]),
        .irq_o(irq[g])
      );

      chk_pin_gated: assert property (@(posedge mclk_i) disable iff (!rst_n)
        ##1 (timer_clk_r[g] == $past(oe_r[g] && latch[g])))
        else $error("clock output pin does not follow the gated latch");
      chk_restart_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n)
        restart_r[g] |=> !restart_r[g] && (cnt[g] == '0))
        else $error("restart bit did not clear itself");
      cov_restart: cover property (@(posedge mclk_i) disable iff (!rst_n)
        mode_r[g].en ##1 restart_r[g]);
      cov_ext_edge: cover property (@(posedge mclk_i) disable iff (!rst_n)
        !mode_r[g].sel[2] && mode_r[g].en && tick[g]);
    end
  endgenerate

  // pin is low while its enable is clear
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_clk_r <= '0;
      timer_irq_r <= '0;
    end
    else
    begin
      timer_clk_r <= oe_r & latch;
      timer_irq_r <= irq;
    end
  end

  always_comb
  begin
    rd_mux = '0;
    for (int c = 0; c < NCH; c++)
    begin
      if (is_idx(s_axi_araddr_i, MODE_IDX[c]))
      begin
        rd_mux[MODE_SEL_LSB +: 3] = mode_r[c].sel;
        rd_mux[MODE_EN_BIT] = mode_r[c].en;
      end
      if (is_idx(s_axi_araddr_i, CNT_IDX[c]))
        rd_mux[CNT_W-1:0] = cnt[c];
      if (is_idx(s_axi_araddr_i, IDX_STAT))
      begin
        rd_mux[STAT_IRQ_LSB + c] = irq[c];
        rd_mux[STAT_LATCH_LSB + c] = latch[c];
      end
      if (is_idx(s_axi_araddr_i, IDX_OUT_EN))
        rd_mux[OE_BIT[c]] = oe_r[c];
    end
    if (is_idx(s_axi_araddr_i, IDX_OUT_EN))
      rd_mux[OE_BASIC_BIT] = basic_oe_r;
  end

  // read side; the reference registers fall through to zero
  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready_i)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;
  assign timer_clk_o = timer_clk_r;
  assign timer_irq_o = timer_irq_r;

  chk_ref_reads_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
    s_axi_arvalid_i && arready_r && (is_idx(s_axi_araddr_i, IDX_REF0) || is_idx(s_axi_araddr_i, IDX_REF1))
    |=> rvalid_r && (rdata_r == '0))
    else $error("compare reference read back a nonzero value");
  chk_unmapped_err: assert property (@(posedge mclk_i) disable iff (!rst_n)
    s_axi_arvalid_i && arready_r && !is_mapped(s_axi_araddr_i) |=> rvalid_r && (rresp_r == RESP_SLVERR))
    else $error("unmapped read did not answer with an error");
  chk_read_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rvalid_r && !s_axi_rready_i |=> rvalid_r && $stable(rdata_r))
    else $error("read answer changed before it was taken");
  chk_write_answer: assert property (@(posedge mclk_i) disable iff (!rst_n)
    do_write |=> bvalid_r ##0 (!awready_r && !wready_r))
    else $error("write was not answered one cycle after both halves arrived");
  chk_oe_reset: assert property (@(posedge mclk_i)
    !rst_n |-> (oe_r == '0) && (timer_clk_r == '0))
    else $error("output enable or pin not cleared by reset");
  cov_unmapped: cover property (@(posedge mclk_i) disable iff (!rst_n)
    rvalid_r && (rresp_r == RESP_SLVERR));
endmodule // cmt_top

// ### verif/cmt_far_side.sv
// far side of both channels: external event clock source and clock output load
// assumes the bench calls pulse() right after a rising edge of clk_i
`timescale 1ns/100ps
module cmt_far_side (
  input wire logic clk_i,
  input wire logic [1:0] timer_clk_i,
  output logic [1:0] event_clk_o
);
  int cyc = 0;
  int last_rise [2] = '{0, 0};
  int period [2] = '{0, 0};
  logic [1:0] prev_r = 2'b00;

  // pins rest low between bursts, as a pulled-down input would
  initial event_clk_o = 2'b00;

  // w sets the high and low time, so bursts can be prompt or slow
  task automatic pulse(input int ch, input int n, input int w);
    repeat (n)
    begin
      @(posedge clk_i);
      event_clk_o[ch] <= 1'b1;
      repeat (w) @(posedge clk_i);
      event_clk_o[ch] <= 1'b0;
      repeat (w + 6) @(posedge clk_i);
    end
  endtask

  // load side: cycles between rising edges of each clock output
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    prev_r <= timer_clk_i;
    for (int i = 0; i < 2; i++)
      if (timer_clk_i[i] === 1'b1 && prev_r[i] === 1'b0)
      begin
        period[i] <= cyc - last_rise[i];
        last_rise[i] <= cyc;
      end
  end
endmodule // cmt_far_side

// ### verif/cmt_top_tb_top.sv
// self-checking bench: register tests over AXI4-Lite, event and divider timing
// assumes cmt_top, cmt_pkg and the far-side model cmt_far_side
`timescale 1ns/100ps
module cmt_top_tb_top;
  import cmt_pkg::*;
  localparam int LIMIT = 80000;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [NCH-1:0] event_clk_i, timer_clk_o, timer_irq_o;
  logic [AXI_AW-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [AXI_DW-1:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int div [2][4] = '{'{1024, 64, 16, 1}, '{4096, 1024, 256, 64}};

  cmt_top u_cmt_top (.mclk_i, .rst_b_i, .event_clk_i, .timer_clk_o, .timer_irq_o,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i);

  cmt_far_side u_cmt_far_side (.clk_i(mclk_i), .timer_clk_i(timer_clk_o), .event_clk_o(event_clk_i));

  always #10 mclk_i = ~mclk_i;

  task automatic complete_run;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // registers are word indices; byte address is four times the index
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr_i <= {2'b00, idx, 2'b00};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1);
    chk({s_axi_bvalid_o, s_axi_bresp_o}, {1'b1, er});
  endtask

  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr_i <= {2'b00, idx, 2'b00};
    s_axi_arvalid_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    chk({s_axi_rvalid_o, s_axi_rresp_o}, {1'b1, er});
    chk(s_axi_rdata_o, exp);
  endtask

  task automatic do_reset;
    rst_b_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  initial
  begin
    do_reset();
    rdc(IDX_CNT0, 32'h00);
    rdc(IDX_CNT1, 32'h00);
    rdc(IDX_OUT_EN, 32'h00);
    rdc(IDX_REF0, 32'h00);
    rdc(IDX_STAT, 32'h00);
    wr(IDX_CNT0, 32'h55);
    rdc(IDX_CNT0, 32'h00);
    wr(12'h000, 32'h01, RESP_SLVERR);
    rdc(12'h000, 32'h00, RESP_SLVERR);
    $display("test reset done");
    wr(IDX_REF0, 32'h03);
    wr(IDX_MODE0, 32'h0c);
    u_cmt_far_side.pulse(0, 3, 2);
    rdc(IDX_CNT0, 32'h03);
    u_cmt_far_side.pulse(0, 1, 5);
    rdc(IDX_CNT0, 32'h00);
    rdc(IDX_STAT, 32'h05);
    chk(timer_irq_o, 2'b01);
    u_cmt_far_side.pulse(0, 2, 2);
    rdc(IDX_CNT0, 32'h02);
    wr(IDX_MODE0, 32'h00);
    u_cmt_far_side.pulse(0, 2, 2);
    rdc(IDX_CNT0, 32'h02);
    rdc(IDX_STAT, 32'h05);
    wr(IDX_MODE0, 32'h0c);
    rdc(IDX_CNT0, 32'h00);
    rdc(IDX_STAT, 32'h04);
    rdc(IDX_MODE0, 32'h04);
    $display("test rising events done");
    wr(IDX_REF1, 32'h01);
    wr(IDX_MODE1, 32'h1c);
    u_cmt_far_side.pulse(1, 1, 2);
    rdc(IDX_CNT1, 32'h01);
    u_cmt_far_side.pulse(1, 1, 5);
    rdc(IDX_CNT1, 32'h00);
    rdc(IDX_STAT, 32'h0e);
    rdc(IDX_CNT0, 32'h00);
    // a write with the low byte lane off is answered but changes nothing
    s_axi_wstrb_i <= 4'he;
    wr(IDX_MODE1, 32'h00);
    s_axi_wstrb_i <= 4'hf;
    rdc(IDX_MODE1, 32'h14);
    wr(IDX_STAT, 32'h02);
    rdc(IDX_STAT, 32'h0c);
    chk(timer_irq_o, 2'b00);
    $display("test falling events done");
    wr(IDX_OUT_EN, 32'h0f);
    rdc(IDX_OUT_EN, 32'h0e);
    chk(timer_clk_o, 2'b11);
    wr(IDX_OUT_EN, 32'h04);
    rdc(IDX_OUT_EN, 32'h04);
    chk(timer_clk_o, 2'b01);
    $display("test output enable done");
    // ref 1 toggles every second tick, so one output period is four ticks
    wr(IDX_REF0, 32'h01);
    wr(IDX_REF1, 32'h01);
    wr(IDX_OUT_EN, 32'h0c);
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 4; k++)
      begin
        wr(ch ? IDX_MODE1 : IDX_MODE0, 32'((k + 4) * 16 + 12));
        repeat (10 * div[ch][k] + 20) @(posedge mclk_i);
        chk(u_cmt_far_side.period[ch], 4 * div[ch][k]);
      end
    $display("test dividers done");
    do_reset();
    chk(timer_clk_o, 2'b00);
    rdc(IDX_CNT0, 32'h00);
    wr(IDX_OUT_EN, 32'h04);
    wr(IDX_MODE0, 32'h7c);
    repeat (1100) @(posedge mclk_i);
    chk(u_cmt_far_side.period[0], 512);
    $display("test second reset done");
    complete_run();
  end
endmodule // cmt_top_tb_top
